//--- include/isp_pkg.sv
package isp_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int FAST_MAX_HZ = 1000;
    localparam int SLOW_MAX_HZ = 10;
    // half period of the fastest accepted pulse train, rounded down
    localparam int FAST_HALF_CYC =
        1_000_000_000 / (2 * FAST_MAX_HZ * CLK_PERIOD_NS);
    localparam int SLOW_HALF_CYC =
        1_000_000_000 / (2 * SLOW_MAX_HZ * CLK_PERIOD_NS);
    localparam int NUM_IN = 6;
    localparam int CH_CNT = 0;
    localparam int CH_SS = 1;
    localparam int ADC_W = 12;
    localparam int ADC_FULL = 4095;
    localparam int PCT_FULL = 100;
    typedef enum logic [2:0] {
        ISP_SS = 3'h0,
        ISP_CNT = 3'h1,
        ISP_CNT_SS = 3'h2,
        ISP_TO = 3'h3,
        ISP_TO_FIRST = 3'h4
    } isp_mode_t;
    typedef enum logic [2:0] {
        ISP_Z_LO_ALARM = 3'h0,
        ISP_Z_LO_NOTIFY = 3'h1,
        ISP_Z_NORMAL = 3'h2,
        ISP_Z_UP_WARN = 3'h3,
        ISP_Z_UP_ALARM = 3'h4
    } isp_zone_t;
    typedef enum logic {
        ISP_STOPPED = 1'b0,
        ISP_STARTED = 1'b1
    } isp_run_t;
endpackage : isp_pkg

//--- logic/isp_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - odd inputs 1 kHz, even inputs 10 Hz
// - edge valid after level stable debounce time
// - rise fires production, fall interruption, once
// - cycle timer re-runs current state action
// - divisor combines raw pulses into one impulse
// - combined mode: fast counts, slow starts/stops
// - timeout without impulse fires interruption record
// - debounced rising edge restarts timeout timer
// - cycle on at first impulse, off at timeout
// - first impulse fires, then per divisor; zero never
// - impulse after timeout counts as new first
// - same debounce for rising and falling edges
// - machine stop disables cycle in timeout modes only
// - analog code spans 0 V to 10 V
// - analog sampled once per sampling interval
// - voltage range maps linearly onto measurement range
// - measurement classified into five zones
// - percentage deviation gives hysteresis on thresholds
// - zone changes only beyond threshold by deviation
module isp_top
    import isp_pkg::*;
#(
    parameter int FAST_MAX_DEB = FAST_HALF_CYC,
    parameter int SLOW_MAX_DEB = SLOW_HALF_CYC,
    parameter int NIN = NUM_IN
)(
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // digital inputs and supervision setup
    input wire logic [NIN-1:0] DIN,
    input wire logic [2:0] MODE,
    input wire logic [31:0] DEB_CYC,
    input wire logic [31:0] DIVISOR,
    input wire logic [31:0] TIMEOUT_CYC,
    input wire logic [31:0] CYCLE_CYC,
    // action triggers and state
    output logic ACT_PROD,
    output logic ACT_INTR,
    output logic ACT_COUNT,
    output logic ACT_FIRST,
    output logic ACT_TIMEOUT,
    output logic ACT_CYCLE,
    output logic RUN_STATE,
    output logic [NIN-1:0] DIN_LEVEL,
    // analog input and setup
    input wire logic [ADC_W-1:0] AIN_CODE,
    input wire logic [31:0] SAMPLE_CYC,
    input wire logic [ADC_W-1:0] VMIN_CODE,
    input wire logic [ADC_W-1:0] VMAX_CODE,
    input wire logic signed [15:0] MEAS_MIN,
    input wire logic signed [15:0] MEAS_MAX,
    input wire logic signed [15:0] TH_LO_ALARM,
    input wire logic signed [15:0] TH_LO_NOTIFY,
    input wire logic signed [15:0] TH_UP_WARN,
    input wire logic signed [15:0] TH_UP_ALARM,
    input wire logic [6:0] DEV_PCT,
    // analog results
    output logic [6:0] AIN_PCT,
    output logic signed [15:0] MEAS_VALUE,
    output logic [2:0] ZONE,
    output logic ZONE_EVT
);
    logic [NIN-1:0] s1_reg, s2_reg, lvlp_reg;
    wire logic [NIN-1:0] lvl_w;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            lvlp_reg <= '0;
        end
        else
        begin
            s1_reg <= DIN;
            s2_reg <= s1_reg;
            lvlp_reg <= lvl_w;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NIN; g++)
        begin : g_deb
            // even index is an odd-numbered, fast input
            localparam int CAP = (g % 2 == 0) ? FAST_MAX_DEB : SLOW_MAX_DEB;
            logic lvl_reg, lvl_next;
            logic [31:0] stab_reg, stab_next, lim;
            always_comb
            begin
                // longer hold would swallow pulses at the top rate
                lim = (DEB_CYC > 32'(CAP)) ? 32'(CAP) : DEB_CYC;
                lvl_next = lvl_reg;
                stab_next = stab_reg;
                if (s2_reg[g] == lvl_reg)
                    stab_next = '0;
                else if (stab_reg + 32'h1 >= lim)
                begin
                    lvl_next = s2_reg[g];
                    stab_next = '0;
                end
                else
                    stab_next = stab_reg + 32'h1;
            end
            always_ff @(posedge CLK)
            begin
                if (RST)
                begin
                    lvl_reg <= 1'b0;
                    stab_reg <= '0;
                end
                else
                begin
                    lvl_reg <= lvl_next;
                    stab_reg <= stab_next;
                end
            end
            assign lvl_w[g] = lvl_reg;
        end
    endgenerate

    isp_mode_t mode;
    logic rise_c, rise_s, fall_s, ss_mode, to_mode, first_evt, cyc_en;
    assign mode = isp_mode_t'(MODE);
    assign rise_c = lvl_w[CH_CNT] & ~lvlp_reg[CH_CNT];
    assign rise_s = lvl_w[CH_SS] & ~lvlp_reg[CH_SS];
    assign fall_s = ~lvl_w[CH_SS] & lvlp_reg[CH_SS];
    assign ss_mode = (mode == ISP_SS) || (mode == ISP_CNT_SS);
    assign to_mode = (mode == ISP_TO) || (mode == ISP_TO_FIRST);

    isp_run_t run_reg, run_next;
    logic [31:0] pcnt_reg, pcnt_next, to_reg, to_next, cyc_reg, cyc_next;
    logic prod_n, intr_n, count_n, first_n, tout_n, cycle_n;

    always_comb
    begin
        run_next = run_reg;
        pcnt_next = pcnt_reg;
        to_next = to_reg;
        cyc_next = cyc_reg;
        prod_n = 1'b0;
        intr_n = 1'b0;
        count_n = 1'b0;
        first_n = 1'b0;
        tout_n = 1'b0;
        cycle_n = 1'b0;
        first_evt = to_mode && rise_c && (run_reg == ISP_STOPPED);
        case (mode)
            ISP_SS, ISP_CNT_SS:
            begin
                if (rise_s)
                begin
                    prod_n = 1'b1;
                    run_next = ISP_STARTED;
                end
                else if (fall_s)
                begin
                    intr_n = 1'b1;
                    run_next = ISP_STOPPED;
                end
            end
            ISP_TO, ISP_TO_FIRST:
            begin
                if (rise_c)
                begin
                    to_next = '0;
                    if (first_evt)
                    begin
                        run_next = ISP_STARTED;
                        pcnt_next = '0;
                        if (mode == ISP_TO)
                            prod_n = 1'b1;
                        else
                            first_n = (DIVISOR != 32'h0);
                    end
                end
                else if (run_reg == ISP_STARTED)
                begin
                    if (to_reg + 32'h1 >= TIMEOUT_CYC)
                    begin
                        tout_n = 1'b1;
                        run_next = ISP_STOPPED;
                        to_next = '0;
                    end
                    else
                        to_next = to_reg + 32'h1;
                end
            end
            default:
            begin
                run_next = run_reg;
            end
        endcase
        // the impulse that opens a run in first mode is not counted
        if (mode != ISP_SS && rise_c && DIVISOR != 32'h0 &&
            !(first_evt && mode == ISP_TO_FIRST))
        begin
            if (pcnt_reg + 32'h1 >= DIVISOR)
            begin
                count_n = 1'b1;
                pcnt_next = '0;
            end
            else
                pcnt_next = pcnt_reg + 32'h1;
        end
        // in timeout modes the cycle only runs while started
        cyc_en = (CYCLE_CYC != 32'h0) &&
            (!to_mode || run_reg == ISP_STARTED);
        if (!cyc_en)
            cyc_next = '0;
        else if (cyc_reg + 32'h1 >= CYCLE_CYC)
        begin
            cycle_n = 1'b1;
            cyc_next = '0;
        end
        else
            cyc_next = cyc_reg + 32'h1;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            run_reg <= ISP_STOPPED;
            pcnt_reg <= '0;
            to_reg <= '0;
            cyc_reg <= '0;
            ACT_PROD <= 1'b0;
            ACT_INTR <= 1'b0;
            ACT_COUNT <= 1'b0;
            ACT_FIRST <= 1'b0;
            ACT_TIMEOUT <= 1'b0;
            ACT_CYCLE <= 1'b0;
            RUN_STATE <= 1'b0;
            DIN_LEVEL <= '0;
        end
        else
        begin
            run_reg <= run_next;
            pcnt_reg <= pcnt_next;
            to_reg <= to_next;
            cyc_reg <= cyc_next;
            ACT_PROD <= prod_n;
            ACT_INTR <= intr_n;
            ACT_COUNT <= count_n;
            ACT_FIRST <= first_n;
            ACT_TIMEOUT <= tout_n;
            ACT_CYCLE <= cycle_n;
            RUN_STATE <= run_next;
            DIN_LEVEL <= lvl_w;
        end
    end

    logic [31:0] smp_reg, smp_next;
    logic smp_vld_reg, smp_vld_next;
    logic [ADC_W-1:0] code_reg, code_next, cc;
    logic signed [31:0] span_v, span_m, rel, meas_c, dev_c;
    logic signed [63:0] prod_c;
    logic [2:0] zu, zd, zone_next;
    logic [31:0] pct_c;

    function automatic logic [2:0] zone_of(input logic signed [31:0] v,
        input logic signed [31:0] off);
        logic [2:0] z;
        z = 3'h0;
        if (v > 32'(TH_LO_ALARM) + off) z = z + 3'h1;
        if (v > 32'(TH_LO_NOTIFY) + off) z = z + 3'h1;
        if (v > 32'(TH_UP_WARN) + off) z = z + 3'h1;
        if (v > 32'(TH_UP_ALARM) + off) z = z + 3'h1;
        return z;
    endfunction : zone_of

    always_comb
    begin
        smp_next = smp_reg + 32'h1;
        smp_vld_next = 1'b0;
        code_next = code_reg;
        if (smp_reg + 32'h1 >= SAMPLE_CYC)
        begin
            smp_next = '0;
            smp_vld_next = 1'b1;
            code_next = AIN_CODE;
        end
        cc = (code_reg < VMIN_CODE) ? VMIN_CODE :
            (code_reg > VMAX_CODE) ? VMAX_CODE : code_reg;
        span_v = $signed({20'h0, VMAX_CODE}) - $signed({20'h0, VMIN_CODE});
        rel = $signed({20'h0, cc}) - $signed({20'h0, VMIN_CODE});
        span_m = 32'(MEAS_MAX) - 32'(MEAS_MIN);
        prod_c = 64'(rel) * 64'(span_m);
        // a flat voltage range pins the value to its minimum
        if (span_v > 32'sh0)
            meas_c = 32'(MEAS_MIN) + 32'(prod_c / 64'(span_v));
        else
            meas_c = 32'(MEAS_MIN);
        // deviation in measurement units equals its voltage share
        dev_c = 32'((64'(span_m) * $signed({57'h0, DEV_PCT})) /
            64'(PCT_FULL));
        zu = zone_of(meas_c, dev_c);
        zd = zone_of(meas_c, -dev_c);
        if (zu > ZONE)
            zone_next = zu;
        else if (zd < ZONE)
            zone_next = zd;
        else
            zone_next = ZONE;
        pct_c = (32'(code_reg) * 32'(PCT_FULL)) / 32'(ADC_FULL);
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            smp_reg <= '0;
            smp_vld_reg <= 1'b0;
            code_reg <= '0;
            AIN_PCT <= '0;
            MEAS_VALUE <= '0;
            ZONE <= ISP_Z_NORMAL;
            ZONE_EVT <= 1'b0;
        end
        else
        begin
            smp_reg <= smp_next;
            smp_vld_reg <= smp_vld_next;
            code_reg <= code_next;
            ZONE_EVT <= smp_vld_reg && (zone_next != ZONE);
            if (smp_vld_reg)
            begin
                AIN_PCT <= pct_c[6:0];
                MEAS_VALUE <= meas_c[15:0];
                ZONE <= zone_next;
            end
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_ss_rise;
        ss_mode && rise_s;
    endsequence
    sequence s_first_imp;
        mode == ISP_TO_FIRST && first_evt && DIVISOR != 32'h0;
    endsequence

    property p_rise_prod;
        s_ss_rise |=> ACT_PROD && RUN_STATE;
    endproperty
    a_rise_prod: assert property (p_rise_prod)
        else $error("validated rise did not start production");
    property p_fall_intr;
        ss_mode && fall_s |=> ACT_INTR && !RUN_STATE;
    endproperty
    a_fall_intr: assert property (p_fall_intr)
        else $error("validated fall did not start interruption");
    property p_prod_once;
        ACT_PROD |=> !ACT_PROD;
    endproperty
    a_prod_once: assert property (p_prod_once)
        else $error("production action fired twice");
    property p_deb;
        lvl_w[CH_SS] != lvlp_reg[CH_SS] |->
            $past(s2_reg[CH_SS]) == lvl_w[CH_SS];
    endproperty
    a_deb: assert property (p_deb)
        else $error("level moved against the synchronised input");
    property p_div_zero;
        DIVISOR == 32'h0 |=> !ACT_COUNT && !ACT_FIRST;
    endproperty
    a_div_zero: assert property (p_div_zero)
        else $error("action fired with zero divisor");
    property p_timeout;
        to_mode && RUN_STATE && !rise_c && to_reg + 32'h1 >= TIMEOUT_CYC
            |=> ACT_TIMEOUT && !RUN_STATE ##1 !ACT_TIMEOUT;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("timeout did not stop the run once");
    property p_to_restart;
        to_mode && rise_c |=> to_reg == 32'h0;
    endproperty
    a_to_restart: assert property (p_to_restart)
        else $error("impulse did not restart timeout");
    property p_cyc_off;
        to_mode && !RUN_STATE && !rise_c |=> !ACT_CYCLE;
    endproperty
    a_cyc_off: assert property (p_cyc_off)
        else $error("cycle ran while stopped");
    property p_first;
        s_first_imp |=> ACT_FIRST && RUN_STATE ##1 !ACT_FIRST;
    endproperty
    a_first: assert property (p_first)
        else $error("first impulse action missing");
    property p_zone_evt;
        ZONE_EVT |-> ZONE != $past(ZONE) && ZONE <= 3'h4;
    endproperty
    a_zone_evt: assert property (p_zone_evt)
        else $error("zone event without zone change");
endmodule : isp_top

//--- sim/isp_field.sv
`timescale 1ns/1ps
module isp_field (
    // clock of the block
    input wire logic clk,
    // levels the machine should settle at
    input wire logic [5:0] want,
    input wire logic chatter,
    input wire logic [11:0] ain_want,
    // contact and transmitter lines
    output logic [5:0] din,
    output logic [11:0] ain
);
    logic [5:0] seen = 6'h00;
    logic [5:0] chg = 6'h00;
    int left = 0;
    initial din = 6'h00;
    initial ain = 12'h000;
    // contacts bounce for three cycles, shorter than any hold in use
    always @(negedge clk)
    begin
        if (want !== seen)
        begin
            chg = want ^ seen;
            seen = want;
            left = 3;
        end
        if (chatter && left > 0)
            din <= left[0] ? want ^ chg : want;
        else
            din <= want;
        if (left > 0)
            left--;
        ain <= ain_want;
    end
endmodule : isp_field

//--- sim/isp_top_test.sv
`timescale 1ns/1ps
module isp_top_test;
    import isp_pkg::*;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic [5:0] want = 6'h00;
    logic chatter = 1'b1;
    logic [11:0] ain_want = 12'h000;
    logic [5:0] din;
    logic [11:0] ain;
    logic [2:0] mode = 3'h0;
    logic [31:0] deb = 32'h4, div = 32'h0, tmo = 32'h0, cyc = 32'h0;
    logic [31:0] samp = 32'h8;
    logic [11:0] vmax = 12'h3E8;
    logic signed [15:0] th [4] = '{16'sh64, 16'sh12C, 16'sh2BC, 16'sh384};
    logic a_prod, a_intr, a_cnt, a_first, a_to, a_cyc, run, zevt;
    logic [5:0] lvl;
    logic [6:0] pct;
    logic signed [15:0] meas;
    logic [2:0] zone;
    int bad_count = 0, checks = 0, i, v, z, zc, n, dv;
    int n_prod, n_intr, n_cnt, n_first, n_to, n_cyc, n_zev;
    int codes [8] = '{500, 280, 250, 320, 351, 760, 4095, 0};
    logic [31:0] rnd = 32'h5D;

    isp_field field (.clk(CLK), .want(want), .chatter(chatter),
        .ain_want(ain_want), .din(din), .ain(ain));
    isp_top #(.FAST_MAX_DEB(20), .SLOW_MAX_DEB(200)) uut (
        .CLK(CLK), .RST(RST), .DIN(din), .MODE(mode), .DEB_CYC(deb),
        .DIVISOR(div), .TIMEOUT_CYC(tmo), .CYCLE_CYC(cyc),
        .ACT_PROD(a_prod), .ACT_INTR(a_intr), .ACT_COUNT(a_cnt),
        .ACT_FIRST(a_first), .ACT_TIMEOUT(a_to), .ACT_CYCLE(a_cyc),
        .RUN_STATE(run), .DIN_LEVEL(lvl), .AIN_CODE(ain),
        .SAMPLE_CYC(samp), .VMIN_CODE(12'h000), .VMAX_CODE(vmax),
        .MEAS_MIN(16'sh0000), .MEAS_MAX(16'(vmax)), .TH_LO_ALARM(th[0]),
        .TH_LO_NOTIFY(th[1]), .TH_UP_WARN(th[2]), .TH_UP_ALARM(th[3]),
        .DEV_PCT(7'h05), .AIN_PCT(pct), .MEAS_VALUE(meas), .ZONE(zone),
        .ZONE_EVT(zevt));

    initial
    begin
        forever #12.5 CLK = ~CLK;
    end

    always @(posedge CLK)
    begin
        n_prod += a_prod;
        n_intr += a_intr;
        n_cnt += a_cnt;
        n_first += a_first;
        n_to += a_to;
        n_cyc += a_cyc;
        n_zev += zevt;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h",
                $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int k);
        repeat (k) @(negedge CLK);
    endtask : tick

    task automatic pulse(input int b, input int hi, input int lo);
        want[b] <= 1'b1;
        tick(hi);
        want[b] <= 1'b0;
        tick(lo);
    endtask : pulse

    // reset also clears the pulse tallies
    task automatic restart(input logic [2:0] m);
        RST <= 1'b1;
        mode <= m;
        tick(3);
        RST <= 1'b0;
        {n_prod, n_intr, n_cnt, n_first, n_to, n_cyc, n_zev} = '0;
    endtask : restart

    function automatic int xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return int'(rnd[15:0]);
    endfunction : xs

    // up past threshold plus deviation, down to threshold minus it
    function automatic int zmodel(input int zi, input int x);
        int t [4] = '{100, 300, 700, 900};
        while (zi < 4 && x > t[zi] + 50) zi++;
        while (zi > 0 && x <= t[zi - 1] - 50) zi--;
        return zi;
    endfunction : zmodel

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        #(25 * 20000);
        bad_count++;
        tally_and_finish();
    end

    initial
    begin
        tick(2);
        RST <= 1'b0;
        tick(1);
        check(run, 0);
        check(zone, 2);
        check(lvl, 0);
        // short glitch on the slow input must be ignored
        want[1] <= 1'b1;
        tick(2);
        want[1] <= 1'b0;
        tick(20);
        check(n_prod, 0);
        want[1] <= 1'b1;
        tick(20);
        check(n_prod, 1);
        check(run, 1);
        check(lvl[1], 1);
        want[1] <= 1'b0;
        tick(20);
        check(n_intr, 1);
        check(run, 0);
        cyc <= 32'h28;
        tick(50);
        n_cyc = 0;
        tick(400);
        check(n_cyc, 10);
        $display("test start_stop done");
        cyc <= 32'h0;
        for (i = 0; i < 4; i++)
        begin
            restart(3'h1);
            dv = xs() % 4 + 1;
            n = xs() % 9 + 1;
            div <= dv;
            tick(1);
            repeat (n) pulse(0, 8, 8);
            check(n_cnt, n / dv);
        end
        restart(3'h2);
        div <= 32'h3;
        want[1] <= 1'b1;
        tick(20);
        repeat (7) pulse(0, 8, 8);
        check(n_prod, 1);
        check(n_cnt, 2);
        want[1] <= 1'b0;
        $display("test counter done");
        restart(3'h3);
        tmo <= 32'h64;
        cyc <= 32'h1E;
        pulse(0, 8, 8);
        tick(60);
        pulse(0, 8, 8);
        tick(60);
        check(n_to, 0);
        check(run, 1);
        check(n_cyc != 0, 1);
        tick(100);
        check(n_to, 1);
        check(run, 0);
        n_cyc = 0;
        tick(100);
        check(n_cyc, 0);
        $display("test timeout done");
        restart(3'h4);
        cyc <= 32'h0;
        div <= 32'h2;
        repeat (5) pulse(0, 8, 8);
        check(n_first, 1);
        check(n_cnt, 2);
        tick(150);
        check(n_to, 1);
        pulse(0, 8, 8);
        check(n_first, 2);
        div <= 32'h0;
        tick(150);
        pulse(0, 8, 8);
        check(n_first, 2);
        check(run, 1);
        $display("test first_impulse done");
        restart(3'h0);
        z = 2;
        zc = 0;
        for (i = 0; i < 16; i++)
        begin
            v = (i < 8) ? codes[i] : xs() % 1101;
            ain_want <= v[11:0];
            tick(30);
            if (zmodel(z, v > 1000 ? 1000 : v) != z)
                zc++;
            z = zmodel(z, v > 1000 ? 1000 : v);
            check(meas, v > 1000 ? 1000 : v);
            check(zone, z);
            if (v == 0 || v == 4095)
                check(pct, v == 0 ? 0 : 100);
        end
        check(n_zev, zc);
        $display("test analog done");
        tally_and_finish();
    end
endmodule : isp_top_test
